// ### include/vsrb_pkg.sv
package vsrb_pkg;
  localparam logic [3:0] VSRB_OFS_SETPOINT_ZERO = 4'h0;
  localparam logic [3:0] VSRB_OFS_SETPOINT_ONE  = 4'h1;
  localparam logic [3:0] VSRB_OFS_RSVD_TWO      = 4'h2;
  localparam logic [3:0] VSRB_OFS_RSVD_THREE    = 4'h3;
  localparam logic [3:0] VSRB_OFS_PULLDOWN      = 4'h4;
  localparam logic [3:0] VSRB_OFS_THERMAL       = 4'h5;
  localparam logic [3:0] VSRB_OFS_SLEW          = 4'h6;
  localparam logic [3:0] VSRB_OFS_RSVD_SEVEN    = 4'h7;
  localparam logic [3:0] VSRB_OFS_PART_ID       = 4'h8;
  localparam logic [3:0] VSRB_OFS_PART_ID_ALT   = 4'h9;
  localparam int         VSRB_MODE_BIT          = 7;
  localparam int         VSRB_CODE_MSB          = 6;
  localparam logic [7:0] VSRB_RST_SP0_A         = 8'h46;
  localparam logic [7:0] VSRB_RST_SP0_B         = 8'h2e;
  localparam logic [7:0] VSRB_RST_SP1_A         = 8'h42;
  localparam logic [7:0] VSRB_RST_SP1_B         = 8'h5a;
  localparam logic [7:0] VSRB_RST_PULLDOWN      = 8'hc0;
  localparam logic [7:0] VSRB_MSK_PULLDOWN      = 8'hc0;
  localparam logic [7:0] VSRB_RST_THERMAL       = 8'h00;
  localparam logic [7:0] VSRB_MSK_THERMAL_WR    = 8'h04;
  localparam logic [7:0] VSRB_RST_SLEW          = 8'h00;
  localparam logic [7:0] VSRB_MSK_SLEW          = 8'he6;
  // Identification value is arbitrary.
  localparam logic [7:0] VSRB_PART_ID_A         = 8'h5a;
  // Identification value is arbitrary.
  localparam logic [7:0] VSRB_PART_ID_B         = 8'h5b;
  localparam int         VSRB_MV_STEP           = 10;
  localparam int         VSRB_MV_BASE           = 500;
endpackage : vsrb_pkg

// ### include/vsrb_sel_if.sv
`timescale 1ns/1ns
interface vsrb_sel_if;
  logic       select;
  logic [7:0] sp_zero;
  logic [7:0] sp_one;
  logic       forced_pw;
  logic [6:0] code;
  modport bank (output select, output sp_zero, output sp_one,
                input forced_pw, input code);
  modport mux  (input select, input sp_zero, input sp_one,
                output forced_pw, output code);
endinterface : vsrb_sel_if

// ### hw/vsrb_setpoint_mux.sv
`timescale 1ns/1ns
module vsrb_setpoint_mux
  import vsrb_pkg::*;
(
  vsrb_sel_if.mux sel
);
  wire [7:0] active_sp;
  assign active_sp = sel.select ? sel.sp_one : sel.sp_zero;
  assign sel.forced_pw = active_sp[VSRB_MODE_BIT];
  assign sel.code      = active_sp[VSRB_CODE_MSB:0];
endmodule : vsrb_setpoint_mux

// ### hw/vsrb_bank.sv
`timescale 1ns/1ns
// Notes on behaviour
// - A low select input applies mode and code of setpoint_zero.
// - Bit 7 of a setpoint picks forced pulse width when 1, auto when 0.
// - Bits 6..0 are a code; output is code times 10 mV plus 500 mV.
// - The first variant resets setpoint_zero to 0x46.
// - The second variant resets setpoint_zero to 0x2e.
// - A high select input applies setpoint_one, laid out the same way.
module vsrb_bank
  import vsrb_pkg::*;
#(
  parameter bit VARIANT_B = 1'b0
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_setpoint_select_input,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_junction_early_warning,
  input  wire logic       i_junction_shutdown_flag,
  output logic      [7:0] o_rdata,
  output logic            o_forced_pulse_width,
  output logic      [6:0] o_voltage_code,
  output logic      [10:0] o_target_mv,
  output logic            o_enable_pin_pulldown,
  output logic            o_select_pin_pulldown,
  output logic            o_thermal_shutdown_disable,
  output logic      [2:0] o_slew_rate_code,
  output logic            o_output_discharge_enable,
  output logic            o_slew_in_light_load
);
  localparam logic [7:0] SP0_RST = VARIANT_B ? VSRB_RST_SP0_B
                                             : VSRB_RST_SP0_A;
  localparam logic [7:0] SP1_RST = VARIANT_B ? VSRB_RST_SP1_B
                                             : VSRB_RST_SP1_A;
  localparam logic [7:0] ID_VAL  = VARIANT_B ? VSRB_PART_ID_B
                                             : VSRB_PART_ID_A;
  localparam logic [10:0] MV_STEP = 11'(VSRB_MV_STEP);
  localparam logic [10:0] MV_BASE = 11'(VSRB_MV_BASE);
  localparam logic [10:0] MV_TOP  = MV_BASE + 11'h07f * MV_STEP;

  logic [1:0] rst_sync_ff;
  logic       rst_n;
  logic [1:0] sel_sync_ff;
  logic [1:0] tw_sync_ff;
  logic [1:0] ts_sync_ff;
  logic [7:0] setpoint_zero_ff;
  logic [7:0] setpoint_one_ff;
  logic [7:0] pulldown_control_ff;
  logic [7:0] thermal_control_ff;
  logic [7:0] slew_control_ff;

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) rst_sync_ff <= 2'b00;
    else rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Checks start one edge after the internal reset lifts, because the
  // registered outputs still show reset values on that first edge.
  logic chk_live_ff;
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) chk_live_ff <= 1'b0;
    else chk_live_ff <= 1'b1;
  end

  // Pins are asynchronous to the clock, so all pass two flops first.
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_sync_ff <= 2'b00;
      tw_sync_ff  <= 2'b00;
      ts_sync_ff  <= 2'b00;
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], i_setpoint_select_input};
      tw_sync_ff  <= {tw_sync_ff[0], i_junction_early_warning};
      ts_sync_ff  <= {ts_sync_ff[0], i_junction_shutdown_flag};
    end
  end

  wire wr_sp0  = i_wr_en && (i_addr == VSRB_OFS_SETPOINT_ZERO);
  wire wr_sp1  = i_wr_en && (i_addr == VSRB_OFS_SETPOINT_ONE);
  wire wr_pd   = i_wr_en && (i_addr == VSRB_OFS_PULLDOWN);
  wire wr_th   = i_wr_en && (i_addr == VSRB_OFS_THERMAL);
  wire wr_slew = i_wr_en && (i_addr == VSRB_OFS_SLEW);
  wire rd_rsvd = i_rd_en && (i_addr == VSRB_OFS_RSVD_TWO
                 || i_addr == VSRB_OFS_RSVD_THREE
                 || i_addr == VSRB_OFS_RSVD_SEVEN);
  // Thermal flags are live status, so only the disable bit is stored.
  wire [7:0] thermal_view = (thermal_control_ff & VSRB_MSK_THERMAL_WR)
                          | {6'h00, tw_sync_ff[1], ts_sync_ff[1]};
  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      VSRB_OFS_SETPOINT_ZERO: rd_mux = setpoint_zero_ff;
      VSRB_OFS_SETPOINT_ONE:  rd_mux = setpoint_one_ff;
      VSRB_OFS_PULLDOWN:      rd_mux = pulldown_control_ff;
      VSRB_OFS_THERMAL:       rd_mux = thermal_view;
      VSRB_OFS_SLEW:          rd_mux = slew_control_ff;
      VSRB_OFS_PART_ID:       rd_mux = ID_VAL;
      VSRB_OFS_PART_ID_ALT:   rd_mux = ID_VAL;
      default:                rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      setpoint_zero_ff    <= SP0_RST;
      setpoint_one_ff     <= SP1_RST;
      pulldown_control_ff <= VSRB_RST_PULLDOWN;
      thermal_control_ff  <= VSRB_RST_THERMAL;
      slew_control_ff     <= VSRB_RST_SLEW;
    end else begin
      if (wr_sp0) setpoint_zero_ff <= i_wdata;
      if (wr_sp1) setpoint_one_ff <= i_wdata;
      if (wr_pd) pulldown_control_ff <= i_wdata & VSRB_MSK_PULLDOWN;
      if (wr_th) thermal_control_ff <= i_wdata & VSRB_MSK_THERMAL_WR;
      if (wr_slew) slew_control_ff <= i_wdata & VSRB_MSK_SLEW;
    end
  end

  vsrb_sel_if sel ();
  assign sel.select  = sel_sync_ff[1];
  assign sel.sp_zero = setpoint_zero_ff;
  assign sel.sp_one  = setpoint_one_ff;
  vsrb_setpoint_mux u_mux (
    .sel (sel)
  );
  wire [10:0] nxt_target_mv = 11'(sel.code) * MV_STEP + MV_BASE;

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata                    <= 8'h00;
      o_forced_pulse_width       <= 1'b0;
      o_voltage_code             <= 7'h00;
      o_target_mv                <= 11'h000;
      o_enable_pin_pulldown      <= 1'b1;
      o_select_pin_pulldown      <= 1'b1;
      o_thermal_shutdown_disable <= 1'b0;
      o_slew_rate_code           <= 3'h0;
      o_output_discharge_enable  <= 1'b0;
      o_slew_in_light_load       <= 1'b0;
    end else begin
      if (i_rd_en) o_rdata <= rd_mux;
      o_forced_pulse_width       <= sel.forced_pw;
      o_voltage_code             <= sel.code;
      o_target_mv                <= nxt_target_mv;
      o_enable_pin_pulldown      <= pulldown_control_ff[7];
      o_select_pin_pulldown      <= pulldown_control_ff[6];
      o_thermal_shutdown_disable <= thermal_control_ff[2];
      o_slew_rate_code           <= slew_control_ff[7:5];
      o_output_discharge_enable  <= slew_control_ff[2];
      o_slew_in_light_load       <= slew_control_ff[1];
    end
  end

  property p_sel_zero;
    @(posedge i_ref_clk) disable iff (!chk_live_ff)
      !sel.select |=> o_voltage_code == $past(setpoint_zero_ff[6:0]);
  endproperty
  a_sel_zero: assert property (p_sel_zero)
    else $error("Low select did not apply setpoint zero.");
  property p_mode;
    @(posedge i_ref_clk) disable iff (!chk_live_ff)
      1'b1 |=> o_forced_pulse_width == $past(sel.select ?
        setpoint_one_ff[7] : setpoint_zero_ff[7]);
  endproperty
  a_mode: assert property (p_mode)
    else $error("Mode output does not follow active setpoint.");
  property p_mv;
    @(posedge i_ref_clk) disable iff (!chk_live_ff)
      ##1 o_target_mv == 11'(o_voltage_code) * MV_STEP + MV_BASE;
  endproperty
  a_mv: assert property (p_mv)
    else $error("Target millivolts wrong for code.");
  property p_reset_sp0;
    @(posedge i_ref_clk) $rose(rst_n) |-> setpoint_zero_ff == SP0_RST;
  endproperty
  a_reset_sp0: assert property (p_reset_sp0)
    else $error("Setpoint zero reset value wrong.");
  sequence s_sel_high;
    sel.select ##1 sel.select;
  endsequence
  property p_sel_one;
    @(posedge i_ref_clk) disable iff (!rst_n)
      s_sel_high |-> o_voltage_code == $past(setpoint_one_ff[6:0]);
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("High select did not apply setpoint one.");
  property p_ro;
    @(posedge i_ref_clk) disable iff (!rst_n)
      i_wr_en && i_addr > VSRB_OFS_SLEW |=> $stable(setpoint_zero_ff)
        && $stable(setpoint_one_ff) && $stable(slew_control_ff)
        && $stable(pulldown_control_ff) && $stable(thermal_control_ff);
  endproperty
  a_ro: assert property (p_ro)
    else $error("Write to read-only space changed a register.");
  property p_wr_rb;
    @(posedge i_ref_clk) disable iff (!rst_n)
      wr_sp0 ##1 (i_rd_en && i_addr == VSRB_OFS_SETPOINT_ZERO && !i_wr_en)
        |=> o_rdata == $past(i_wdata, 2);
  endproperty
  a_wr_rb: assert property (p_wr_rb)
    else $error("Setpoint zero readback mismatch.");
  property p_id;
    @(posedge i_ref_clk) disable iff (!rst_n)
      i_rd_en && i_addr == VSRB_OFS_PART_ID |=> o_rdata == ID_VAL;
  endproperty
  a_id: assert property (p_id)
    else $error("Identification readback wrong.");
  property p_rsvd_rd;
    @(posedge i_ref_clk) disable iff (!chk_live_ff)
      rd_rsvd |=> o_rdata == 8'h00;
  endproperty
  a_rsvd_rd: assert property (p_rsvd_rd)
    else $error("Reserved location did not read as zero.");
  property p_rdata_hold;
    @(posedge i_ref_clk) disable iff (!chk_live_ff)
      !i_rd_en |=> $stable(o_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("Read data changed without a read.");
  property p_mv_range;
    @(posedge i_ref_clk) disable iff (!chk_live_ff)
      1'b1 |=> (o_target_mv >= MV_BASE) && (o_target_mv <= MV_TOP);
  endproperty
  a_mv_range: assert property (p_mv_range)
    else $error("Target millivolts outside the programmable range.");
endmodule : vsrb_bank

// ### verif/vsrb_host.sv
`timescale 1ns/1ns
module vsrb_host (
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rdata,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [3:0] o_addr,
  output logic      [7:0] o_wdata
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 4'h0;
    o_wdata = 8'h00;
  end
  // Released address and data are inverted so stale values never look valid.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask : wr
  // Write, then read back on the very next edge, the tightest spacing.
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(negedge i_ref_clk);
    o_addr  = a;
    o_wdata = d;
    o_wr_en = 1'b1;
    @(negedge i_ref_clk);
    o_wr_en = 1'b0;
    o_rd_en = 1'b1;
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
    q = i_rdata;
  endtask : wr_rd
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    o_addr  = a;
    o_rd_en = 1'b1;
    @(negedge i_ref_clk);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    @(negedge i_ref_clk);
    d = i_rdata;
  endtask : rd
endmodule : vsrb_host

// ### verif/vsrb_bank_bench.sv
`timescale 1ns/1ns
module vsrb_bank_bench
  import vsrb_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, sel = 1'b0, jw = 1'b0, js = 1'b0;
  logic wr, rd;
  logic [3:0] addr;
  logic [7:0] wd, rdat, r, d, v;
  logic [6:0] code, code_b;
  logic [10:0] mv;
  logic fpw, fpw_b;
  logic epd, spd, tsd, ode, sll;
  logic [2:0] src;
  logic [3:0] ra;
  logic [7:0] pd_m = VSRB_RST_PULLDOWN, th_m = VSRB_RST_THERMAL;
  logic [7:0] sl_m = VSRB_RST_SLEW;
  wire  [7:0] cfg = {epd, spd, tsd, src, ode, sll};
  logic [31:0] seed = 32'h2668_0a97;
  int failures = 0, tests_run = 0, cyc = 0;
  always #50 clk = ~clk;
  vsrb_host host (.i_ref_clk(clk), .i_rdata(rdat), .o_wr_en(wr),
    .o_rd_en(rd), .o_addr(addr), .o_wdata(wd));
  vsrb_bank #(.VARIANT_B(1'b0)) dut (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_setpoint_select_input(sel), .i_wr_en(wr), .i_rd_en(rd),
    .i_addr(addr), .i_wdata(wd), .i_junction_early_warning(jw),
    .i_junction_shutdown_flag(js), .o_rdata(rdat),
    .o_forced_pulse_width(fpw), .o_voltage_code(code), .o_target_mv(mv),
    .o_enable_pin_pulldown(epd), .o_select_pin_pulldown(spd),
    .o_thermal_shutdown_disable(tsd), .o_slew_rate_code(src),
    .o_output_discharge_enable(ode), .o_slew_in_light_load(sll));
  vsrb_bank #(.VARIANT_B(1'b1)) dut_b (.i_ref_clk(clk), .i_reset_n(rst_n),
    .i_setpoint_select_input(sel), .i_wr_en(1'b0), .i_rd_en(1'b0),
    .i_addr(addr), .i_wdata(wd), .i_junction_early_warning(jw),
    .i_junction_shutdown_flag(js), .o_rdata(),
    .o_forced_pulse_width(fpw_b), .o_voltage_code(code_b), .o_target_mv(),
    .o_enable_pin_pulldown(), .o_select_pin_pulldown(),
    .o_thermal_shutdown_disable(), .o_slew_rate_code(),
    .o_output_discharge_enable(), .o_slew_in_light_load());
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Reserved bits read as zero and the status bits follow the pins.
  function automatic logic [7:0] exp_rd(input logic [3:0] a,
    input logic [7:0] x, input logic w, input logic s);
    case (a)
      4'h0, 4'h1: exp_rd = x;
      4'h4:       exp_rd = x & 8'hc0;
      4'h5:       exp_rd = {5'h00, x[2], w, s};
      4'h6:       exp_rd = x & 8'he6;
      4'h8, 4'h9: exp_rd = VSRB_PART_ID_A;
      default:    exp_rd = 8'h00;
    endcase
  endfunction : exp_rd
  function automatic logic [10:0] exp_mv(input logic [6:0] c);
    exp_mv = 11'(c * VSRB_MV_STEP + VSRB_MV_BASE);
  endfunction : exp_mv
  // Configuration pins as the register map places them.
  function automatic logic [7:0] exp_cfg(input logic [7:0] p,
    input logic [7:0] t, input logic [7:0] s);
    exp_cfg = {p[7:6], t[2], s[7:5], s[2:1]};
  endfunction : exp_cfg
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // The whole run takes about 140 cycles; the ceiling leaves margin.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk(11'(code_b), 11'(VSRB_RST_SP0_B[6:0]));
    chk(11'(fpw_b), 11'h000);
    chk(mv, 11'h4b0);
    chk(11'(cfg), 11'(exp_cfg(pd_m, th_m, sl_m)));
    host.rd(4'h0, r);
    chk(11'(r), 11'h046);
    host.rd(4'h1, r);
    chk(11'(r), 11'h042);
    host.rd(4'h8, r);
    chk(11'(r), 11'(VSRB_PART_ID_A));
    host.rd(4'h9, r);
    chk(11'(r), 11'(VSRB_PART_ID_A));
    host.rd(4'h2, r);
    chk(11'(r), 11'h000);
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      ra = (i == 0) ? 4'h4 : (i == 1) ? 4'h6 : (i == 2) ? 4'h5
         : seed[15:12];
      d = (i == 0) ? 8'h3f : (i < 3) ? 8'hff : seed[7:0];
      jw = seed[8];
      js = seed[9];
      host.wr_rd(ra, d, r);
      chk(11'(r), 11'(exp_rd(ra, d, jw, js)));
      if (ra == VSRB_OFS_PULLDOWN) pd_m = d & VSRB_MSK_PULLDOWN;
      if (ra == VSRB_OFS_THERMAL) th_m = d & VSRB_MSK_THERMAL_WR;
      if (ra == VSRB_OFS_SLEW) sl_m = d & VSRB_MSK_SLEW;
      chk(11'(cfg), 11'(exp_cfg(pd_m, th_m, sl_m)));
    end
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : seed[7:0];
      host.wr_rd(4'h0, v, r);
      chk(11'(r), 11'(v));
      host.wr(4'h1, ~v);
      sel = 1'b0;
      repeat (4) @(negedge clk);
      chk(11'(code), 11'(v[6:0]));
      chk(11'(fpw), 11'(v[7]));
      chk(mv, exp_mv(v[6:0]));
      sel = 1'b1;
      repeat (4) @(negedge clk);
      chk(11'(code), {4'h0, ~v[6:0]});
      chk(11'(fpw), 11'(!v[7]));
      chk(mv, exp_mv(~v[6:0]));
    end
    results();
  end
endmodule : vsrb_bank_bench
